/* File: logic/adc_readout_port.sv */
// Purpose: Device end: reset, busy, oversampling select and readout port.
// Assumes: Link pins sampled by sys_clk through two flops.
// Notes: Results come from a user-side sample port when conversion ends.
//
// Behaviour
// [R01] Reset input clears all digital state
// [R02] Host resets after power-up and shutdown
// [R03] Reset mid-conversion abandons it
// [R04] Reset during read zeroes result registers
// [R05] Host waits after reset before starting
// [R06] Serial clock rising edge times transfers
// [R07] Bus driven only while select and strobe low
// [R08] Select rising edge floats all outputs; the code floats marker and bus, serial lines are driven low
// [R09] Select falling edge starts new frame
// [R10] Serial: enable outputs, present MSB at once
// [R11] Three select inputs form oversampling code
// [R12] Busy rises after both start edges
// [R13] Start inputs ignored while busy
// [R14] Busy holds until results latched
// [R15] Host finishes reading before busy falls
// [R16] Marker leaves float on select falling
// [R17] Parallel marker high first, low third edge
// [R18] Byte marker high three edges, low fourth
// [R19] Serial marker low at eighteenth falling edge
// [R20] Parallel top pins split bits per pulse
// [R21] Interface select and top pin pick mode
// [R22] Byte order pin picks byte sequence
// [R23] Channels go out in ascending order
// [R24] Serial A carries 1-4, B carries 5-8
`timescale 1ns/1ns
`default_nettype none
module adc_readout_port #(
    parameter int CONV_CYCLES = adc_port_pkg::CONV_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Link
    adc_port_if.device link,
    // User side: sample values and oversampling code
    input wire logic [adc_port_pkg::CHANNELS*adc_port_pkg::RESULT_BITS-1:0] sampleIn,
    output logic [adc_port_pkg::OSR_W-1:0] osrCode,
    output logic converting
);
    localparam int RB = adc_port_pkg::RESULT_BITS;
    localparam int NCH = adc_port_pkg::CHANNELS;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [9:0] syncA;
    logic [9:0] syncB;
    logic [2:0] busSyncA;
    logic [2:0] busSyncB;
    logic prevStartA, prevStartB, prevCs, prevRd;

    // Two flops on every control input pin and on bus pins 15 and 14
    always_ff @(posedge sys_clk) begin
        syncA <= {link.resetPin, link.convStartA, link.convStartB, link.csN,
                  link.rdSclkN, link.oversamplingRatioSelect, link.interfaceSelect, 1'b0};
        syncB <= syncA;
        busSyncA <= {link.busIn[15], link.busIn[14], 1'b0};
        busSyncB <= busSyncA;
    end

    wire pinReset = syncB[9];
    wire startA = syncB[8];
    wire startB = syncB[7];
    wire csN = syncB[6];
    wire rdN = syncB[5];
    wire [2:0] osrPins = syncB[4:2];
    wire ifSel = syncB[1];
    wire byteSelPin = busSyncB[2];
    wire orderPin = busSyncB[1];
    wire anyReset = rst | pinReset; // R01

    // Edge detection on synchronised pins
    always_ff @(posedge sys_clk) begin
        prevStartA <= startA;
        prevStartB <= startB;
        prevCs <= csN;
        prevRd <= rdN;
    end

    wire riseA = startA & ~prevStartA;
    wire riseB = startB & ~prevStartB;
    wire csFall = prevCs & ~csN;
    wire csRise = ~prevCs & csN;
    wire rdFall = prevRd & ~rdN;
    wire sclkRise = ~prevRd & rdN;

    // Mode decode: low interface select is parallel
    wire adc_port_pkg::mode_t mode = !ifSel ? adc_port_pkg::MODE_PAR :
        (byteSelPin ? adc_port_pkg::MODE_BYTE : adc_port_pkg::MODE_SER); // R21

    // ---------------------------------------------------------------
    // Conversion control
    // ---------------------------------------------------------------
    logic seenA, seenB, busy;
    logic [adc_port_pkg::CNT_W-1:0] convCnt;
    logic [RB-1:0] result [NCH];
    logic frameOpen;

    wire bothSeen = (seenA | riseA) & (seenB | riseB);
    wire convDone = busy && convCnt == adc_port_pkg::CNT_W'(CONV_CYCLES - 1);

    // Busy and start capture; aborted by reset
    always_ff @(posedge sys_clk) begin
        if (anyReset) begin
            busy <= 1'b0; // R03
            seenA <= 1'b0;
            seenB <= 1'b0;
            convCnt <= '0;
        end else if (busy) begin
            convCnt <= convCnt + 1'b1; // R13
            if (convDone) begin
                busy <= 1'b0; // R14
            end
        end else if (bothSeen) begin
            busy <= 1'b1; // R12
            seenA <= 1'b0;
            seenB <= 1'b0;
            convCnt <= '0;
        end else begin
            seenA <= seenA | riseA;
            seenB <= seenB | riseB;
        end
    end

    // Result registers, latched at end of conversion
    generate
        for (genvar c = 0; c < NCH; c++) begin : g_res
            always_ff @(posedge sys_clk) begin
                if (anyReset) begin
                    result[c] <= '0; // R04
                end else if (convDone) begin
                    result[c] <= sampleIn[c*RB +: RB]; // R14
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Readout frame
    // ---------------------------------------------------------------
    logic [adc_port_pkg::CHAN_W-1:0] chan;
    logic [1:0] part;
    logic [6:0] bitIdx;
    logic [6:0] edgeCnt;
    logic marker, markerOe, outOe;
    logic [15:0] busOut;
    logic serA, serB;

    wire [RB-1:0] cur = result[chan];
    wire [7:0] byteHi = cur[17:10];
    wire [7:0] byteMid = cur[9:2];
    wire [7:0] byteLo = {cur[1:0], 6'h00};
    wire [7:0] byteOut = orderPin ?
        (part == 2'd0 ? byteHi : part == 2'd1 ? byteMid : byteLo) :
        (part == 2'd0 ? byteLo : part == 2'd1 ? byteMid : byteHi); // R22
    // Parallel word: top pins carry 17/16 then 10/0, rest 15..2 then zeros
    wire [15:0] parWord = (part == 2'd0) ? {cur[17], cur[16], cur[15:2]} :
        {cur[10], cur[0], 14'h0000}; // R20
    // Next serial bit: channel and position after the coming clock rise
    wire [6:0] nextIdx = bitIdx + 7'd1;
    wire [1:0] serCh = 2'(nextIdx / 7'(RB));
    wire [4:0] serBit = 5'(RB - 1 - int'(nextIdx % 7'(RB)));
    wire nextSerA = result[{1'b0, serCh}][serBit]; // R24
    wire nextSerB = result[{1'b1, serCh}][serBit];
    wire strobeLow = ~csN & ~rdN;

    // Frame sequencer: steps per strobe or serial clock
    always_ff @(posedge sys_clk) begin
        if (anyReset | csRise) begin
            frameOpen <= 1'b0;
            chan <= '0;
            part <= '0;
            bitIdx <= '0;
            edgeCnt <= '0;
            marker <= 1'b0;
            markerOe <= 1'b0; // R08
            outOe <= 1'b0;
            busOut <= '0;
            serA <= 1'b0;
            serB <= 1'b0;
        end else if (csFall) begin
            frameOpen <= 1'b1; // R09
            chan <= '0;
            part <= '0;
            bitIdx <= '0;
            edgeCnt <= '0;
            markerOe <= 1'b1; // R16
            marker <= (mode == adc_port_pkg::MODE_SER); // R19
            outOe <= (mode == adc_port_pkg::MODE_SER); // R10
            serA <= result[0][RB-1]; // R10
            serB <= result[4][RB-1];
        end else if (frameOpen) begin
            unique case (mode)
                adc_port_pkg::MODE_SER: begin
                    if (sclkRise && bitIdx < 7'(adc_port_pkg::SERIAL_BITS - 1)) begin
                        bitIdx <= bitIdx + 1'b1; // R06
                        serA <= nextSerA; // R24
                        serB <= nextSerB;
                    end
                    if (rdFall) begin
                        edgeCnt <= edgeCnt + 1'b1;
                        if (edgeCnt == 7'(adc_port_pkg::MARKER_SERIAL_EDGE - 1)) begin
                            marker <= 1'b0; // R19
                        end
                    end
                end
                adc_port_pkg::MODE_PAR: begin
                    outOe <= strobeLow; // R07
                    if (rdFall) begin
                        edgeCnt <= edgeCnt + 1'b1;
                        busOut <= parWord;
                        marker <= (edgeCnt < 7'(adc_port_pkg::MARKER_PAR_EDGE - 1)); // R17
                        part <= part == 2'd0 ? 2'd1 : 2'd0;
                        if (part == 2'd1) begin
                            chan <= chan + 1'b1; // R23
                        end
                    end
                end
                default: begin
                    outOe <= strobeLow; // R07
                    if (rdFall) begin
                        edgeCnt <= edgeCnt + 1'b1;
                        busOut <= {8'h00, byteOut};
                        marker <= (edgeCnt < 7'(adc_port_pkg::MARKER_BYTE_EDGE - 1)); // R18
                        part <= part == 2'd2 ? 2'd0 : part + 1'b1;
                        if (part == 2'd2) begin
                            chan <= chan + 1'b1; // R23
                        end
                    end
                end
            endcase
        end
    end

    // Output pins and user-side status
    always_ff @(posedge sys_clk) begin
        if (anyReset) begin
            osrCode <= '0;
            converting <= 1'b0;
        end else begin
            osrCode <= osrPins; // R11
            converting <= busy;
        end
    end

    wire isPar = (mode == adc_port_pkg::MODE_PAR);
    wire isByte = (mode == adc_port_pkg::MODE_BYTE);
    logic [15:0] busEnable;

    // Bus enables registered so the pins leave straight from flops
    always_ff @(posedge sys_clk) begin
        if (anyReset) begin
            busEnable <= 16'h0000;
        end else begin
            busEnable <= (outOe & isPar) ? 16'hffff : (outOe & isByte) ? 16'h00ff : 16'h0000; // R07
        end
    end

    assign link.busy = busy;
    assign link.markerOut = marker;
    assign link.markerOe = markerOe;
    assign link.busOut = busOut;
    assign link.busOe = busEnable;
    assign link.serialOutA = serA;
    assign link.serialOutB = serB;
endmodule
`default_nettype wire

/* File: logic/adc_port_pkg.sv */
// Purpose: Shared constants for the converter readout port and its host.
// Assumes: 18-bit results, eight channels, link pins sampled on sys_clk.
// Notes: Timing counts derive from the 25 MHz system clock.
package adc_port_pkg;
    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int RESULT_BITS = 18;
    localparam int CHANNELS = 8;
    localparam int CHAN_W = 3;
    localparam int HALF_CHANNELS = 4;
    localparam int SERIAL_BITS = RESULT_BITS * HALF_CHANNELS;
    localparam int BUS_W = 16;
    localparam int OSR_W = 3;
    localparam int MARKER_SERIAL_EDGE = 18;
    localparam int MARKER_PAR_EDGE = 3;
    localparam int MARKER_BYTE_EDGE = 4;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int SYS_CLK_MHZ = 25;
    localparam int CONV_TIME_NS = 4000;
    localparam int CONV_CYCLES = (CONV_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 12;
    localparam int DIV_HALF = 4;
    // ---------------------------------------------------------------
    // Host register map (AHB-Lite word offsets)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RESULT0 = 8'h20;
    localparam int CTL_START = 0;
    localparam int CTL_RESET = 1;
    localparam int CTL_READ = 2;
    localparam int CTL_IFSEL = 3;
    localparam int CTL_BYTESEL = 4;
    localparam int CTL_ORDER = 5;
    localparam int CTL_OSR = 8;
    localparam int CTL_HOLD = 11;
    localparam int CTL_LOW_RESULT = 12;
    // Readout modes
    typedef enum logic [1:0] {
        MODE_PAR = 2'b00,
        MODE_SER = 2'b01,
        MODE_BYTE = 2'b10
    } mode_t;
endpackage

/* File: logic/adc_port_if.sv */
// Purpose: Pin-level link between the converter port and its host.
// Assumes: Both ends run on their own sys_clk.
// Notes: Two-way pins carry in, out and enable; the host drives the in side directly.
`timescale 1ns/1ns
`default_nettype none
interface adc_port_if;
    logic resetPin;
    logic convStartA;
    logic convStartB;
    logic csN;
    logic rdSclkN;
    logic [2:0] oversamplingRatioSelect;
    logic interfaceSelect;
    logic busy;
    logic markerOut;
    logic markerOe;
    logic [15:0] busOut;
    logic [15:0] busOe;
    logic [15:0] busIn;
    logic serialOutA;
    logic serialOutB;
    modport device (
        input resetPin, convStartA, convStartB, csN, rdSclkN,
        input oversamplingRatioSelect, interfaceSelect, busIn,
        output busy, markerOut, markerOe, busOut, busOe, serialOutA, serialOutB
    );
    modport host (
        output resetPin, convStartA, convStartB, csN, rdSclkN,
        output oversamplingRatioSelect, interfaceSelect, busIn,
        input busy, markerOut, markerOe, busOut, busOe, serialOutA, serialOutB
    );
endinterface
`default_nettype wire

/* File: logic/adc_host_ctrl.sv */
// Purpose: Host end: drives reset, starts, strobes and reads results.
// Assumes: AHB-Lite slave, single word transfers, zero wait states.
// Notes: Serial clock derived by divider from sys_clk.
`timescale 1ns/1ns
`default_nettype none
module adc_host_ctrl #(
    parameter int DIV_HALF = adc_port_pkg::DIV_HALF
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Link
    adc_port_if.host link
);
    logic [15:0] ctl;
    logic [7:0] wAddr;
    logic wPend;
    logic [2:0] dSync;
    logic [2:0] dSync2;
    logic rdLevel;
    logic [7:0] divCnt;
    logic [31:0] word;

    wire accept = hsel & htrans[1];

    // ---------------------------------------------------------------
    // Bus slave
    // ---------------------------------------------------------------
    // Address phase capture and write data phase
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wPend <= 1'b0;
            wAddr <= '0;
            ctl <= 16'h0000;
            hrdata <= '0;
        end else begin
            wPend <= accept & hwrite;
            wAddr <= haddr;
            if (wPend && wAddr == adc_port_pkg::OFS_CONTROL) begin
                ctl <= hwdata[15:0];
            end
            if (accept && !hwrite) begin
                hrdata <= (haddr == adc_port_pkg::OFS_CONTROL) ? {16'h0000, ctl} :
                    (haddr == adc_port_pkg::OFS_STATUS) ? {16'h0000, word[15:0] & 16'h0000} | {29'h0, dSync2} : 
                    (haddr == adc_port_pkg::OFS_RESULT0) ? word : 32'h0;
            end
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Sample device pins through two flops: busy, marker, serial A
    always_ff @(posedge sys_clk) begin
        dSync <= {link.busy, link.markerOut, link.serialOutA};
        dSync2 <= dSync;
    end

    // Strobe and serial clock divider runs while the read bit is set, in any mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            divCnt <= '0;
            rdLevel <= 1'b1;
            word <= '0;
        end else if (ctl[adc_port_pkg::CTL_READ]) begin
            if (divCnt == 8'(DIV_HALF - 1)) begin
                divCnt <= '0;
                rdLevel <= ~rdLevel;
                if (!rdLevel) begin
                    word <= {word[30:0], dSync2[0]};
                end
            end else begin
                divCnt <= divCnt + 1'b1;
            end
        end else begin
            divCnt <= '0;
            rdLevel <= 1'b1;
        end
    end

    assign link.resetPin = ctl[adc_port_pkg::CTL_RESET]; // R02
    assign link.convStartA = ctl[adc_port_pkg::CTL_START]; // R05
    assign link.convStartB = ctl[adc_port_pkg::CTL_START];
    assign link.csN = ~ctl[adc_port_pkg::CTL_HOLD];
    assign link.rdSclkN = rdLevel; // R15
    assign link.oversamplingRatioSelect = ctl[adc_port_pkg::CTL_OSR +: 3];
    assign link.interfaceSelect = ctl[adc_port_pkg::CTL_IFSEL];
    assign link.busIn = {ctl[adc_port_pkg::CTL_BYTESEL], ctl[adc_port_pkg::CTL_ORDER], 14'h0000};
endmodule
`default_nettype wire

/* File: sim/adc_port_checker.sv */
// Purpose: Concurrent checks on the pin link between converter port and host.
// Assumes: Both ends share sys_clk; the device syncs link pins in two flops.
// Notes: Delay windows allow for the synchroniser and output registers.
`timescale 1ns/1ns
`default_nettype none
module adc_port_checker #(
    parameter int CONV_CYCLES = adc_port_pkg::CONV_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Pins from host
    input wire logic resetPin,
    input wire logic convStartA,
    input wire logic convStartB,
    input wire logic csN,
    input wire logic rdSclkN,
    input wire logic interfaceSelect,
    input wire logic [15:0] busIn,
    // Pins from device
    input wire logic busy,
    input wire logic markerOut,
    input wire logic markerOe,
    input wire logic [15:0] busOe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Helper: length of the current busy pulse
    // ------------------------------------------------------------
    logic [11:0] busyLen;
    // Counts cycles while busy is high
    always_ff @(posedge sys_clk) begin
        if (rst || !busy) begin
            busyLen <= 12'h000;
        end else begin
            busyLen <= busyLen + 12'h001;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_busy_rise;
        $rose(convStartA) && convStartB && !busy |-> ##[1:8] busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");
    property p_busy_len;
        disable iff (rst || resetPin)
        $fell(busy) |-> busyLen >= CONV_CYCLES - 2 && busyLen <= CONV_CYCLES + 2;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_no_restart;
        $fell(busy) |=> !busy[*6];
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("busy restarted");
    property p_reset_abort;
        $rose(resetPin) |-> ##[1:6] !busy;
    endproperty
    a_reset_abort: assert property (p_reset_abort) else $error("busy kept in reset");
    property p_reset_quiet;
        resetPin[*6] |-> !busy && !markerOe && busOe == 16'h0000;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output live in reset");
    property p_cs_float;
        csN[*6] |-> busOe == 16'h0000 && !markerOe;
    endproperty
    a_cs_float: assert property (p_cs_float) else $error("driven while deselected");
    property p_bus_strobe;
        (csN || rdSclkN)[*6] |-> busOe == 16'h0000;
    endproperty
    a_bus_strobe: assert property (p_bus_strobe) else $error("bus driven without strobe");
    property p_top_input;
        interfaceSelect[*6] |-> busOe[15:14] == 2'b00;
    endproperty
    a_top_input: assert property (p_top_input) else $error("top pins driven");
    property p_marker_first;
        $fell(csN) && interfaceSelect && !busIn[15] |-> ##[1:6] markerOe && markerOut;
    endproperty
    a_marker_first: assert property (p_marker_first) else $error("marker not up");
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench joining host controller and converter port.
// Assumes: Bench is AHB-Lite master of the host; samples fed on the user side.
// Notes: Conversion count shortened; serial clock comes from the host divider.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int CONV = 40;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [143:0] sampleIn = '0;
    logic [2:0] osrCode;
    logic converting;
    int seed = 87;
    int n_mismatch = 0;
    int samples_checked = 0;
    int model [8];
    // ------------------------------------------------------------
    // Clock, link and the two ends
    // ------------------------------------------------------------
    always #20 sys_clk = ~sys_clk;
    adc_port_if link();
    adc_readout_port #(.CONV_CYCLES(CONV)) adc_readout_port_inst (.sys_clk(sys_clk),
        .rst(rst), .link(link.device), .sampleIn(sampleIn), .osrCode(osrCode),
        .converting(converting));
    adc_host_ctrl adc_host_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link.host));
    adc_port_checker #(.CONV_CYCLES(CONV)) adc_port_checker_inst (.sys_clk(sys_clk),
        .rst(rst), .resetPin(link.resetPin), .convStartA(link.convStartA),
        .convStartB(link.convStartB), .csN(link.csN), .rdSclkN(link.rdSclkN),
        .interfaceSelect(link.interfaceSelect), .busIn(link.busIn), .busy(link.busy),
        .markerOut(link.markerOut), .markerOe(link.markerOe), .busOe(link.busOe));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // One single-word AHB-Lite transfer, address phase then data phase
    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wdata;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rdata = hrdata;
        check("response", {31'h0, hresp}, 32'h0);
    endtask
    task automatic set_ctl(input logic [31:0] v);
        logic [31:0] unused;
        ahb(1'b1, adc_port_pkg::OFS_CONTROL, v, unused);
    endtask
    task automatic wait_busy(input logic lvl);
        int cyc;
        cyc = 0;
        while (link.busy !== lvl && cyc < 1000) begin
            @(posedge sys_clk);
            cyc++;
        end
        if (cyc >= 1000) n_mismatch++;
    endtask
    // Converts, with a start edge inside busy, then latches the model
    task automatic convert();
        logic [31:0] st;
        logic [159:0] r;
        r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
        sampleIn <= r[143:0];
        set_ctl(32'h0000_0001);
        wait_busy(1'b1);
        ahb(1'b0, adc_port_pkg::OFS_STATUS, 32'h0, st);
        check("status busy", {31'h0, st[2]}, 32'h1);
        check("converting", {31'h0, converting}, 32'h1);
        set_ctl(32'h0000_0000);
        set_ctl(32'h0000_0001);
        wait_busy(1'b0);
        for (int c = 0; c < 8; c++) model[c] = int'(sampleIn[c*18 +: 18]);
        set_ctl(32'h0000_0000);
    endtask
    // Serial frame: compares both lines at every clock fall, may reset mid-read
    task automatic read_serial(input int abortAt);
        int falls;
        int cyc;
        logic prevClk;
        set_ctl(32'h0000_0008);
        set_ctl(32'h0000_0808);
        set_ctl(32'h0000_080c);
        falls = 0;
        cyc = 0;
        prevClk = link.rdSclkN;
        while (falls < 72 && (abortAt == 0 || falls != abortAt) && cyc < 3000) begin
            @(posedge sys_clk);
            cyc++;
            if (prevClk === 1'b1 && link.rdSclkN === 1'b0) begin
                check("line a", {31'h0, link.serialOutA}, (model[falls/18] >> (17 - falls%18)) & 1);
                check("line b", {31'h0, link.serialOutB}, (model[4 + falls/18] >> (17 - falls%18)) & 1);
                falls++;
                if (falls == 18) check("marker high", {31'h0, link.markerOut}, 32'h1);
                if (falls == 19) check("marker low", {31'h0, link.markerOut}, 32'h0);
            end
            prevClk = link.rdSclkN;
        end
        if (abortAt != 0) begin
            set_ctl(32'h0000_080e);
            repeat (10) @(posedge sys_clk);
            for (int c = 0; c < 8; c++) model[c] = 0;
        end else begin
            check("frame bits", falls, 72);
        end
        set_ctl(32'h0000_0008);
        repeat (20) @(posedge sys_clk);
    endtask
    // Parallel or byte frame: bus, enables and marker checked at each strobe rise
    task automatic read_bus(input logic [31:0] cfg, input int nStrobe);
        int n;
        int m;
        int p;
        int expWord;
        logic prevClk;
        n = 0;
        set_ctl(cfg);
        set_ctl(cfg | 32'h0000_0800);
        set_ctl(cfg | 32'h0000_0804);
        prevClk = link.rdSclkN;
        while (n < nStrobe) begin
            @(posedge sys_clk);
            if (prevClk === 1'b0 && link.rdSclkN === 1'b1) begin
                m = model[cfg[4] ? n / 3 : n / 2];
                p = cfg[5] ? n % 3 : 2 - n % 3;
                expWord = (n % 2 == 0) ? m >> 2 & 16'hffff :
                    (m >> 10 & 1) << 15 | (m & 1) << 14;
                if (cfg[4]) begin
                    expWord = (p == 0) ? m >> 10 & 255 : (p == 1) ? m >> 2 & 255 : (m & 3) << 6;
                end
                check("bus data", {16'h0, link.busOut}, expWord);
                check("bus enable", {16'h0, link.busOe}, cfg[4] ? 32'h00ff : 32'hffff);
                check("marker", {31'h0, link.markerOut}, n < (cfg[4] ? 3 : 2));
                n++;
            end
            prevClk = link.rdSclkN;
        end
        set_ctl(cfg);
        repeat (20) @(posedge sys_clk);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        set_ctl(32'h0000_0002);
        repeat (10) @(posedge sys_clk);
        set_ctl(32'h0000_0000);
        repeat (20) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            set_ctl(32'(i) << 8);
            repeat (6) @(posedge sys_clk);
            check("osr code", {29'h0, osrCode}, 32'(i));
        end
        ahb(1'b0, 8'h10, 32'h0, rd);
        check("unmapped read", rd, 32'h0);
        repeat (2) begin
            convert();
            read_serial(0);
            read_serial(0);
            read_bus(32'h0000_0000, 16);
            read_bus(32'h0000_0038, 24);
            read_bus(32'h0000_0018, 24);
        end
        read_serial(20);
        read_serial(0);
        set_ctl(32'h0000_0001);
        wait_busy(1'b1);
        set_ctl(32'h0000_0003);
        repeat (8) @(posedge sys_clk);
        check("busy aborted", {31'h0, link.busy}, 32'h0);
        set_ctl(32'h0000_0000);
        repeat (10) @(posedge sys_clk);
        finish_test();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        finish_test();
    end
endmodule
`default_nettype wire
